//--- opr_params.svh
// constants for the otp program control and pin output register slice
`ifndef OPR_PARAMS_SVH
`define OPR_PARAMS_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define OPR_IDX_PROG_CTRL   10'h107
`define OPR_IDX_PIN_LEVELS  10'h108
`define OPR_IDX_UNLOCK_1    10'h1F0
`define OPR_IDX_UNLOCK_2    10'h1F1
`define OPR_IDX_PIN_DIR     10'h1F2
`define OPR_IDX_STATUS      10'h1F3
`define OPR_ADDR_W          12
`define OPR_ADDR_OF(idx)    {idx, 2'b00}

// ****************************************
// field positions and widths
// ****************************************
`define OPR_BIT_TRIGGER     0
`define OPR_BIT_PAGE        1
`define OPR_PINS            6
`define OPR_CODE_W          8
`define OPR_STAT_BUSY       0
`define OPR_STAT_REFUSED    1
`define OPR_STAT_UNLOCKED   2
`define OPR_STAT_PIN_LSB    8

// ****************************************
// reset values and bus answers
// ****************************************
`define OPR_RST_BYTE        8'h00
`define OPR_RST_PINS        6'h00
`define OPR_RESP_OKAY       2'h0
`define OPR_RESP_SLVERR     2'h2

`endif

//--- opr_pkg.sv
// types shared by the otp program control and pin output register slice
package opr_pkg;

    // ****************************************
    // programming sequencer states
    // ****************************************
    typedef enum logic [0:0] {
        OPR_IDLE,
        OPR_PROGRAM
    } opr_state_type;

    // ****************************************
    // register selected by an address
    // ****************************************
    typedef enum logic [2:0] {
        OPR_SEL_NONE,
        OPR_SEL_CTRL,
        OPR_SEL_PINS,
        OPR_SEL_UNLK1,
        OPR_SEL_UNLK2,
        OPR_SEL_DIR,
        OPR_SEL_STAT
    } opr_sel_type;

endpackage

//--- opr_regs.sv
// axi4-lite register slice: otp page program control and io pin output levels
`include "opr_params.svh"

// What this block does
// - trigger set starts programming of page chosen by page select, zero first
// - programming only proceeds when both unlock registers hold correct codes
// - trigger reads zero when idle, one while programming is requested
// - pin level bits zero to five drive io pins one to six
// - a pin level only reaches its pin while that pin is an output
// - level zero drives low, level one drives high
module opr_regs #(
    parameter logic [`OPR_CODE_W-1:0] UNLOCK_FIRST_CODE  = 8'h5A,
    parameter logic [`OPR_CODE_W-1:0] UNLOCK_SECOND_CODE = 8'hC3
) (
    input  wire logic                   clock_in,
    input  wire logic                   rstn_in,
    input  wire logic [`OPR_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                   s_axi_awvalid_in,
    output logic                        s_axi_awready_out,
    input  wire logic [31:0]            s_axi_wdata_in,
    input  wire logic [3:0]             s_axi_wstrb_in,
    input  wire logic                   s_axi_wvalid_in,
    output logic                        s_axi_wready_out,
    output logic [1:0]                  s_axi_bresp_out,
    output logic                        s_axi_bvalid_out,
    input  wire logic                   s_axi_bready_in,
    input  wire logic [`OPR_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                   s_axi_arvalid_in,
    output logic                        s_axi_arready_out,
    output logic [31:0]                 s_axi_rdata_out,
    output logic [1:0]                  s_axi_rresp_out,
    output logic                        s_axi_rvalid_out,
    input  wire logic                   s_axi_rready_in,
    output logic                        otp_program_start_out,
    output logic                        otp_page_select_out,
    input  wire logic                   otp_program_done_in,
    input  wire logic [`OPR_PINS-1:0]   io_pin_in,
    output logic [`OPR_PINS-1:0]        io_pin_level_out,
    output logic [`OPR_PINS-1:0]        io_pin_oe_out
);

    // ****************************************
    // declarations
    // ****************************************
    logic                     rst_meta_ff;
    logic                     rst_n_ff;
    logic                     aw_held_ff,  nxt_aw_held;
    logic [`OPR_ADDR_W-1:0]   aw_addr_ff,  nxt_aw_addr;
    logic                     w_held_ff,   nxt_w_held;
    logic [31:0]              w_data_ff,   nxt_w_data;
    logic                     w_lane0_ff,  nxt_w_lane0;
    logic                     bvalid_ff,   nxt_bvalid;
    logic [1:0]               bresp_ff,    nxt_bresp;
    logic                     rvalid_ff,   nxt_rvalid;
    logic [1:0]               rresp_ff,    nxt_rresp;
    logic [31:0]              rdata_ff,    nxt_rdata;
    logic                     wr_fire;
    opr_pkg::opr_sel_type     wr_sel;
    opr_pkg::opr_state_type   state_ff,    nxt_state;
    logic                     trigger_ff,  nxt_trigger;
    logic                     page_ff,     nxt_page;
    logic                     start_ff,    nxt_start;
    logic                     refused_ff,  nxt_refused;
    logic [`OPR_CODE_W-1:0]   unlock1_ff,  nxt_unlock1;
    logic [`OPR_CODE_W-1:0]   unlock2_ff,  nxt_unlock2;
    logic [`OPR_PINS-1:0]     levels_ff,   nxt_levels;
    logic [`OPR_PINS-1:0]     dir_ff,      nxt_dir;
    logic [`OPR_PINS-1:0]     pin_s1_ff;
    logic [`OPR_PINS-1:0]     pin_s2_ff;
    logic [`OPR_PINS-1:0]     pin_s3_ff;
    logic [`OPR_PINS-1:0]     pin_seen_ff;
    logic                     unlocked;
    logic                     wr_ctrl_go;

    // ****************************************
    // address decode
    // ****************************************
    function automatic opr_pkg::opr_sel_type opr_decode(input logic [`OPR_ADDR_W-1:0] addr);
        unique case (addr)
            `OPR_ADDR_OF(`OPR_IDX_PROG_CTRL):  opr_decode = opr_pkg::OPR_SEL_CTRL;
            `OPR_ADDR_OF(`OPR_IDX_PIN_LEVELS): opr_decode = opr_pkg::OPR_SEL_PINS;
            `OPR_ADDR_OF(`OPR_IDX_UNLOCK_1):   opr_decode = opr_pkg::OPR_SEL_UNLK1;
            `OPR_ADDR_OF(`OPR_IDX_UNLOCK_2):   opr_decode = opr_pkg::OPR_SEL_UNLK2;
            `OPR_ADDR_OF(`OPR_IDX_PIN_DIR):    opr_decode = opr_pkg::OPR_SEL_DIR;
            `OPR_ADDR_OF(`OPR_IDX_STATUS):     opr_decode = opr_pkg::OPR_SEL_STAT;
            default:                           opr_decode = opr_pkg::OPR_SEL_NONE;
        endcase
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    // two flops so the release is clean against clock_in
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ****************************************
    // axi write and read channels
    // ****************************************
    // address and data are latched separately; write fires once both are held
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_sel  = opr_decode(aw_addr_ff);

    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_lane0 = w_lane0_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rresp   = rresp_ff;
        nxt_rdata   = rdata_ff;
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            nxt_w_held  = 1'b1;
            nxt_w_data  = s_axi_wdata_in;
            nxt_w_lane0 = s_axi_wstrb_in[0];
        end
        if (wr_fire)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (wr_sel == opr_pkg::OPR_SEL_NONE) ? `OPR_RESP_SLVERR : `OPR_RESP_OKAY;
        end
        else if (bvalid_ff && s_axi_bready_in)
        begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `OPR_RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            unique case (opr_decode(s_axi_araddr_in))
                opr_pkg::OPR_SEL_CTRL:
                begin
                    nxt_rdata[`OPR_BIT_TRIGGER] = trigger_ff;
                    nxt_rdata[`OPR_BIT_PAGE]    = page_ff;
                end
                opr_pkg::OPR_SEL_PINS:  nxt_rdata[`OPR_PINS-1:0]   = levels_ff;
                opr_pkg::OPR_SEL_UNLK1: nxt_rdata[`OPR_CODE_W-1:0] = unlock1_ff;
                opr_pkg::OPR_SEL_UNLK2: nxt_rdata[`OPR_CODE_W-1:0] = unlock2_ff;
                opr_pkg::OPR_SEL_DIR:   nxt_rdata[`OPR_PINS-1:0]   = dir_ff;
                opr_pkg::OPR_SEL_STAT:
                begin
                    nxt_rdata[`OPR_STAT_BUSY]     = (state_ff == opr_pkg::OPR_PROGRAM);
                    nxt_rdata[`OPR_STAT_REFUSED]  = refused_ff;
                    nxt_rdata[`OPR_STAT_UNLOCKED] = unlocked;
                    nxt_rdata[`OPR_STAT_PIN_LSB +: `OPR_PINS] = pin_seen_ff;
                end
                opr_pkg::OPR_SEL_NONE:  nxt_rresp = `OPR_RESP_SLVERR;
            endcase
        end
        else if (rvalid_ff && s_axi_rready_in)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_lane0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `OPR_RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `OPR_RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_lane0_ff <= nxt_w_lane0;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
        end
    end

    // bus outputs
    assign s_axi_awready_out = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready_out  = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = !rvalid_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rresp_out   = rresp_ff;
    assign s_axi_rdata_out   = rdata_ff;

    // ****************************************
    // otp programming control
    // ****************************************
    // both codes match
    assign unlocked   = (unlock1_ff == UNLOCK_FIRST_CODE) && (unlock2_ff == UNLOCK_SECOND_CODE);
    assign wr_ctrl_go = wr_fire && w_lane0_ff && (wr_sel == opr_pkg::OPR_SEL_CTRL);

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_trigger = trigger_ff;
        nxt_page    = page_ff;
        nxt_start   = 1'b0;
        nxt_refused = refused_ff;
        nxt_unlock1 = unlock1_ff;
        nxt_unlock2 = unlock2_ff;
        nxt_levels  = levels_ff;
        nxt_dir     = dir_ff;
        if (wr_fire && w_lane0_ff)
        begin
            unique case (wr_sel)
                opr_pkg::OPR_SEL_UNLK1: nxt_unlock1 = w_data_ff[`OPR_CODE_W-1:0];
                opr_pkg::OPR_SEL_UNLK2: nxt_unlock2 = w_data_ff[`OPR_CODE_W-1:0];
                opr_pkg::OPR_SEL_PINS:  nxt_levels = w_data_ff[`OPR_PINS-1:0];
                opr_pkg::OPR_SEL_DIR:   nxt_dir = w_data_ff[`OPR_PINS-1:0];
                // refused flag is write one to clear
                opr_pkg::OPR_SEL_STAT:
                    nxt_refused = refused_ff & ~w_data_ff[`OPR_STAT_REFUSED];
                default:                nxt_state = state_ff;
            endcase
        end
        unique case (state_ff)
            opr_pkg::OPR_IDLE:
            begin
                if (wr_ctrl_go)
                begin
                    nxt_page = w_data_ff[`OPR_BIT_PAGE];
                    if (w_data_ff[`OPR_BIT_TRIGGER] && unlocked)
                    begin
                        nxt_state   = opr_pkg::OPR_PROGRAM;
                        nxt_trigger = 1'b1;
                        nxt_start   = 1'b1;
                    end
                    else if (w_data_ff[`OPR_BIT_TRIGGER])
                    begin
                        nxt_refused = 1'b1;
                    end
                end
            end
            opr_pkg::OPR_PROGRAM:
            begin
                if (otp_program_done_in)
                begin
                    nxt_state   = opr_pkg::OPR_IDLE;
                    nxt_trigger = 1'b0;
                    nxt_unlock1 = `OPR_RST_BYTE;
                    nxt_unlock2 = `OPR_RST_BYTE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff   <= opr_pkg::OPR_IDLE;
            trigger_ff <= 1'b0;
            page_ff    <= 1'b0;
            start_ff   <= 1'b0;
            refused_ff <= 1'b0;
            unlock1_ff <= `OPR_RST_BYTE;
            unlock2_ff <= `OPR_RST_BYTE;
            levels_ff  <= `OPR_RST_PINS;
            dir_ff     <= `OPR_RST_PINS;
        end
        else
        begin
            state_ff   <= nxt_state;
            trigger_ff <= nxt_trigger;
            page_ff    <= nxt_page;
            start_ff   <= nxt_start;
            refused_ff <= nxt_refused;
            unlock1_ff <= nxt_unlock1;
            unlock2_ff <= nxt_unlock2;
            levels_ff  <= nxt_levels;
            dir_ff     <= nxt_dir;
        end
    end

    assign otp_program_start_out = start_ff;
    assign otp_page_select_out   = page_ff;

    // ****************************************
    // io pins
    // ****************************************
    // each pin input passes three flops; a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < `OPR_PINS; i++)
        begin : g_pin
            always_ff @(posedge clock_in or negedge rst_n_ff)
            begin
                if (!rst_n_ff)
                begin
                    pin_s1_ff[i]   <= 1'b0;
                    pin_s2_ff[i]   <= 1'b0;
                    pin_s3_ff[i]   <= 1'b0;
                    pin_seen_ff[i] <= 1'b0;
                end
                else
                begin
                    pin_s1_ff[i]   <= io_pin_in[i];
                    pin_s2_ff[i]   <= pin_s1_ff[i];
                    pin_s3_ff[i]   <= pin_s2_ff[i];
                    pin_seen_ff[i] <= (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i] : pin_seen_ff[i];
                end
            end
            assign io_pin_oe_out[i]    = dir_ff[i];
            assign io_pin_level_out[i] = levels_ff[i] & dir_ff[i];
        end
    endgenerate

    // ****************************************
    // assertions
    // ****************************************
    default clocking opr_cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_ff);

    chk_start_unlocked: assert property (start_ff |-> $past(unlocked))
        else $error("programming started while locked");
    chk_locked_refused: assert property (wr_ctrl_go && w_data_ff[`OPR_BIT_TRIGGER] && !unlocked
        |=> !start_ff && refused_ff)
        else $error("locked trigger not refused");
    chk_start_page: assert property (start_ff |-> trigger_ff
        && otp_page_select_out == $past(w_data_ff[`OPR_BIT_PAGE]))
        else $error("start without page or trigger");
    chk_trigger_state: assert property (trigger_ff == (state_ff == opr_pkg::OPR_PROGRAM))
        else $error("trigger does not match busy");
    chk_done_ready: assert property (state_ff == opr_pkg::OPR_PROGRAM && otp_program_done_in
        |=> !trigger_ff && !unlocked)
        else $error("done did not return to ready");
    chk_pin_write: assert property (wr_fire && w_lane0_ff && wr_sel == opr_pkg::OPR_SEL_PINS
        |=> levels_ff == $past(w_data_ff[`OPR_PINS-1:0]))
        else $error("pin levels not stored");
    chk_pin_gated: assert property ((io_pin_level_out & ~io_pin_oe_out) == 6'h00)
        else $error("level on a non-output pin");
    chk_pin_level: assert property (((io_pin_level_out ^ levels_ff) & dir_ff) == 6'h00)
        else $error("pin level differs from stored bit");
    chk_ctrl_reserved: assert property (s_axi_arvalid_in && s_axi_arready_out
        && opr_decode(s_axi_araddr_in) == opr_pkg::OPR_SEL_CTRL |=> rdata_ff[31:2] == 30'h0)
        else $error("reserved control bits not zero");
    chk_write_answer: assert property (aw_held_ff && w_held_ff && !bvalid_ff |=> bvalid_ff)
        else $error("write response missing");

endmodule

//--- opr_regs_tb_top.sv
// self-checking bench for the otp program control and pin output register slice
`include "opr_params.svh"

module opr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // constants, stimulus and bookkeeping
    // ****************************************
    localparam logic [7:0]  CODE_A = 8'h5A;  // unlock codes of this bench
    localparam logic [7:0]  CODE_B = 8'hC3;
    localparam int          LIMIT  = 6000;   // a generous ceiling on the whole run
    localparam logic [11:0] A_CTRL = `OPR_ADDR_OF(`OPR_IDX_PROG_CTRL);
    localparam logic [11:0] A_PINS = `OPR_ADDR_OF(`OPR_IDX_PIN_LEVELS);
    localparam logic [11:0] A_UNL1 = `OPR_ADDR_OF(`OPR_IDX_UNLOCK_1);
    localparam logic [11:0] A_UNL2 = `OPR_ADDR_OF(`OPR_IDX_UNLOCK_2);
    localparam logic [11:0] A_DIR  = `OPR_ADDR_OF(`OPR_IDX_PIN_DIR);
    localparam logic [11:0] A_STAT = `OPR_ADDR_OF(`OPR_IDX_STATUS);
    logic        clock_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [11:0] s_axi_awaddr_in = 12'h000;
    logic        s_axi_awvalid_in = 1'b0;
    logic        s_axi_awready_out;
    logic [31:0] s_axi_wdata_in = 32'h00000000;
    logic [3:0]  s_axi_wstrb_in = 4'h0;
    logic        s_axi_wvalid_in = 1'b0;
    logic        s_axi_wready_out;
    logic [1:0]  s_axi_bresp_out;
    logic        s_axi_bvalid_out;
    logic        s_axi_bready_in = 1'b0;
    logic [11:0] s_axi_araddr_in = 12'h000;
    logic        s_axi_arvalid_in = 1'b0;
    logic        s_axi_arready_out;
    logic [31:0] s_axi_rdata_out;
    logic [1:0]  s_axi_rresp_out;
    logic        s_axi_rvalid_out;
    logic        s_axi_rready_in = 1'b0;
    logic        otp_program_start_out;
    logic        otp_page_select_out;
    logic        otp_program_done_in = 1'b0;
    logic [5:0]  io_pin_in = 6'h00;
    logic [5:0]  io_pin_level_out;
    logic [5:0]  io_pin_oe_out;
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          starts = 0;
    logic        start_page = 1'b0;
    logic [31:0] rd;
    logic [1:0]  rs;

    opr_regs #(.UNLOCK_FIRST_CODE(CODE_A), .UNLOCK_SECOND_CODE(CODE_B)) dut (
        .clock_in(clock_in), .rstn_in(rstn_in),
        .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
        .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
        .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
        .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
        .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
        .s_axi_rready_in(s_axi_rready_in), .otp_program_start_out(otp_program_start_out),
        .otp_page_select_out(otp_page_select_out), .otp_program_done_in(otp_program_done_in),
        .io_pin_in(io_pin_in), .io_pin_level_out(io_pin_level_out),
        .io_pin_oe_out(io_pin_oe_out));

    // 20 MHz clock, 50 ns period
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end

    // ****************************************
    // monitors, hang guard and closing report
    // ****************************************
    // count start pulses and note the page each one names
    always @(posedge clock_in)
    begin
        cycles++;
        if (otp_program_start_out === 1'b1)
        begin
            starts++;
            start_page = otp_page_select_out;
        end
        if (cycles == LIMIT)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ****************************************
    // axi4-lite master tasks
    // ****************************************
    // offer address and data together, release each once taken, then wait for the answer
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data,
                             output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clock_in);
        s_axi_awaddr_in <= addr;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wdata_in <= data;
        s_axi_wstrb_in <= 4'hF;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clock_in);
            if (!aw_ok && s_axi_awready_out === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid_in <= 1'b0;
            end
            if (!w_ok && s_axi_wready_out === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid_in <= 1'b0;
            end
        end
        do @(posedge clock_in); while (s_axi_bvalid_out !== 1'b1);
        resp = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        @(posedge clock_in);
        s_axi_araddr_in <= addr;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge clock_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        while (s_axi_rvalid_out !== 1'b1) @(posedge clock_in);
        data = s_axi_rdata_out;
        resp = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // both registers and the pin outputs come up cleared
    task automatic t_reset_values();
        axi_read(A_CTRL, rd, rs);
        chk("ctrl reset", 32'h00000000, rd);
        axi_read(A_PINS, rd, rs);
        chk("pins reset", 32'h00000000, rd);
        chk("pins resp", 32'h00000000, {30'h0, rs});
        chk("level out reset", 32'h00000000, {26'h0, io_pin_level_out});
    endtask

    // each level bit reaches its own pin, only while that pin is an output
    task automatic t_pin_levels();
        axi_write(A_DIR, 32'h0000003F, rs);
        axi_write(A_PINS, 32'hFFFFFFFF, rs);
        axi_read(A_PINS, rd, rs);
        chk("pins readback", 32'h0000003F, rd);
        chk("pins driven high", 32'h0000003F, {26'h0, io_pin_level_out});
        for (int i = 0; i < 6; i++)
        begin
            axi_write(A_PINS, 32'h1 << i, rs);
            chk("one pin high", 32'h1 << i, {26'h0, io_pin_level_out});
        end
        axi_write(A_PINS, 32'h0000003F, rs);
        axi_write(A_DIR, 32'h00000015, rs);
        chk("inputs not driven", 32'h00000015, {26'h0, io_pin_level_out});
        chk("enables", 32'h00000015, {26'h0, io_pin_oe_out});
        axi_write(A_PINS, 32'h00000000, rs);
        chk("pins driven low", 32'h00000000, {26'h0, io_pin_level_out});
    endtask

    // unlock, trigger page p, ignore a write while busy, finish, then refuse a locked retry
    task automatic t_program(input logic p);
        int s0;
        s0 = starts;
        axi_write(A_UNL1, {24'h0, CODE_A}, rs);
        axi_write(A_UNL2, {24'h0, CODE_B}, rs);
        axi_write(A_CTRL, {30'h0, p, 1'b1}, rs);
        @(posedge clock_in);
        chk("one start", s0 + 1, starts);
        chk("start page", {31'h0, p}, {31'h0, start_page});
        axi_read(A_CTRL, rd, rs);
        chk("trigger busy", {30'h0, p, 1'b1}, rd);
        axi_read(A_STAT, rd, rs);
        chk("busy unlocked", 32'h00000005, rd & 32'h00000007);
        axi_write(A_CTRL, {30'h0, ~p, 1'b1}, rs);
        @(posedge clock_in);
        chk("busy write", s0 + 1, starts);
        otp_program_done_in <= 1'b1;
        @(posedge clock_in);
        otp_program_done_in <= 1'b0;
        axi_read(A_CTRL, rd, rs);
        chk("trigger idle", 32'h00000000, rd & 32'h00000001);
        axi_write(A_CTRL, 32'h00000001, rs);
        @(posedge clock_in);
        chk("locked retry", s0 + 1, starts);
        axi_read(A_STAT, rd, rs);
        chk("refused flag", 32'h00000002, rd & 32'h00000002);
        axi_write(A_STAT, 32'h00000002, rs);
        axi_read(A_STAT, rd, rs);
        chk("refused cleared", 32'h00000000, rd & 32'h00000007);
    endtask

    // pins that are inputs show up, synchronised, in the status word
    task automatic t_pin_inputs();
        io_pin_in <= 6'h2A;
        repeat (4) @(posedge clock_in);
        axi_read(A_STAT, rd, rs);
        chk("pin inputs seen", 32'h00002A00, rd & 32'h00003F00);
    endtask

    // an address with no register answers with an error
    task automatic t_unmapped();
        axi_write(12'h004, 32'h000000FF, rs);
        chk("unmapped write", {30'h0, `OPR_RESP_SLVERR}, {30'h0, rs});
        axi_read(12'h004, rd, rs);
        chk("unmapped read", {30'h0, `OPR_RESP_SLVERR}, {30'h0, rs});
        chk("unmapped data", 32'h00000000, rd);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        t_reset_values();
        t_pin_levels();
        t_program(1'b0);
        t_program(1'b1);
        t_unmapped();
        t_pin_inputs();
        wrap_up();
    end
endmodule
